/* rtl/pfs_defines.svh */
// Purpose: named constants of the parallel frequency setpoint block
// Assumes: frequencies in 0.01 Hz units, register index addressing
// Notes:   definitions only
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
// register indexes
`define PFS_A_METHOD  4'h0
`define PFS_A_RTIME   4'h1
`define PFS_A_BCDBIAS 4'h2
`define PFS_A_BCDGAIN 4'h3
`define PFS_A_BINBIAS 4'h4
`define PFS_A_BINGAIN 4'h5
`define PFS_A_INC     4'h6
`define PFS_A_CTRL    4'h7
`define PFS_A_CMD     4'h8
`define PFS_A_STAT    4'h9
// setting codes and limits
`define PFS_OFF       16'h270F
`define PFS_DIRECT    16'h270F
`define PFS_FMAX      16'h9C40
`define PFS_GAIN60    16'h1770
`define PFS_GAIN50    16'h1388
`define PFS_BIAS_RST  16'h0000
`define PFS_INC_RST   2'h1
`define PFS_INC_MAX   16'h0003
`define PFS_RT_FREE   16'h0000
`define PFS_RT_STRB   16'h0001
`define PFS_RT_FILT   16'h000A
`define PFS_M_NARROW  16'h0003
`define PFS_M_WIDE    16'h000A
`define PFS_M_LAST    16'h000D
// full scale per code
`define PFS_FS_BCD3   17'h003E7
`define PFS_FS_BCD4   17'h0270F
`define PFS_FS_BIN12  17'h00FFF
`define PFS_FS_BIN16  17'h0FFFF
// direct mode multipliers, 0.01 Hz units
`define PFS_MUL_0     32'h000003E8
`define PFS_MUL_1     32'h00000064
`define PFS_MUL_2     32'h0000000A
`define PFS_MUL_3     32'h00000001
// timing
`define PFS_CLK_MHZ   250
`define PFS_FILT_US   1000
`endif

/* rtl/pfs_pkg.sv */
// Purpose: types of the parallel frequency setpoint block
// Assumes: nothing
// Notes:   constants live in pfs_defines.svh
package pfs_pkg;
    typedef enum logic [1:0] {PFS_IDLE, PFS_DIV, PFS_OUT} pfs_st_t;
    typedef logic [15:0] pfs_word_t;
endpackage

/* rtl/pfs_dp_if.sv */
// Purpose: datapath bundle between control, decoder and scaler
// Assumes: one clock
// Notes:   no clocking block
interface pfs_dp_if;
    logic [15:0] word;
    logic        bcd;
    logic        wide;
    logic [15:0] value;
    logic        bad;
    logic        start;
    logic [15:0] sval;
    logic [15:0] bias;
    logic [15:0] gain;
    logic [1:0]  inc;
    logic        busy;
    logic        done;
    logic [31:0] result;
    modport dec (input word, bcd, output value, bad);
    modport scl (input start, sval, bias, gain, inc, bcd, wide, output busy, done, result);
endinterface

/* rtl/pfs_decode.sv */
// Purpose: turns the captured word into a number
// Assumes: unused upper lines already zeroed
// Notes:   purely combinational
`include "pfs_defines.svh"
module pfs_decode
    import pfs_pkg::*;
(
    pfs_dp_if.dec dp
);
    logic [3:0] dig_bad;

    // per digit range check
    for (genvar g = 0; g < 4; g++) begin : g_dig
        assign dig_bad[g] = (dp.word[4*g+3 -: 4] > 4'h9);
    end

    // bcd weights digits, binary passes straight
    always_comb begin
        if (dp.bcd) begin
            dp.value = 16'(dp.word[3:0]) + 16'(dp.word[7:4]) * 16'h000A
                     + 16'(dp.word[11:8]) * 16'h0064 + 16'(dp.word[15:12]) * 16'h03E8; // RULE4
        end else begin
            dp.value = dp.word; // RULE4
        end
        dp.bad = dp.bcd & (|dig_bad); // RULE19
    end
endmodule // pfs_decode

/* rtl/pfs_scale.sv */
// Purpose: maps a decoded value to a frequency command
// Assumes: start only while idle
// Notes:   restoring divide, 32 steps per interpolation
`include "pfs_defines.svh"
module pfs_scale
    import pfs_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    pfs_dp_if.scl     dp
);
    pfs_st_t     st_r, st_nxt;
    logic [31:0] num_r, num_nxt;
    logic [16:0] rem_r, rem_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [31:0] res_r, res_nxt;
    logic        done_r, done_nxt;
    logic [17:0] rem_sh;
    logic [16:0] fs;
    logic [15:0] span;
    logic [31:0] mul, bias32, gain32, val;

    assign dp.busy   = (st_r != PFS_IDLE);
    assign dp.done   = done_r;
    assign dp.result = res_r;

    // operand selection
    always_comb begin
        if (dp.bcd) fs = dp.wide ? `PFS_FS_BCD4 : `PFS_FS_BCD3; // RULE11
        else        fs = dp.wide ? `PFS_FS_BIN16 : `PFS_FS_BIN12; // RULE11
        span   = (dp.gain >= dp.bias) ? dp.gain - dp.bias : dp.bias - dp.gain;
        bias32 = 32'(dp.bias);
        gain32 = 32'(dp.gain);
        unique case (dp.inc) // RULE18
            2'h0: mul = `PFS_MUL_0;
            2'h1: mul = `PFS_MUL_1;
            2'h2: mul = `PFS_MUL_2;
            2'h3: mul = `PFS_MUL_3;
        endcase
        if (dp.gain >= dp.bias) val = bias32 + num_r; // RULE20
        else if (num_r > bias32) val = 32'h00000000;
        else val = bias32 - num_r; // RULE20
    end

    // sequencer and divider
    always_comb begin
        st_nxt   = st_r;
        num_nxt  = num_r;
        rem_nxt  = rem_r;
        cnt_nxt  = cnt_r;
        res_nxt  = res_r;
        done_nxt = 1'b0;
        rem_sh   = {rem_r, num_r[31]};
        unique case (st_r)
            PFS_IDLE: if (dp.start) begin
                if (dp.gain == `PFS_DIRECT) begin
                    res_nxt  = 32'(dp.sval) * mul; // RULE13 RULE14 RULE18
                    done_nxt = 1'b1;
                end else begin
                    num_nxt = 32'(span) * 32'(dp.sval); // RULE10 RULE11
                    rem_nxt = 17'h00000;
                    cnt_nxt = 5'h00;
                    st_nxt  = PFS_DIV;
                end
            end
            PFS_DIV: begin
                if (rem_sh >= {1'b0, fs}) begin
                    rem_nxt = 17'(rem_sh - {1'b0, fs});
                    num_nxt = {num_r[30:0], 1'b1};
                end else begin
                    rem_nxt = rem_sh[16:0];
                    num_nxt = {num_r[30:0], 1'b0};
                end
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == 5'h1F) st_nxt = PFS_OUT;
            end
            PFS_OUT: begin
                res_nxt  = (val > gain32) ? gain32 : val; // RULE12
                done_nxt = 1'b1;
                st_nxt   = PFS_IDLE;
            end
            default: st_nxt = PFS_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r   <= PFS_IDLE;
            num_r  <= 32'h00000000;
            rem_r  <= 17'h00000;
            cnt_r  <= 5'h00;
            res_r  <= 32'h00000000;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            num_r  <= num_nxt;
            rem_r  <= rem_nxt;
            cnt_r  <= cnt_nxt;
            res_r  <= res_nxt;
            done_r <= done_nxt;
        end
    end
endmodule // pfs_scale

/* rtl/pfs_setpoint.sv */
// Purpose: parallel setpoint word to inverter frequency command
// Assumes: lines and strobe are asynchronous pins, drive_running_in is local
// Notes:   command in 0.01 Hz units, registers on a plain strobe port
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "pfs_defines.svh"
//
// Contract
// RULE1: setting 9999 in input_method_select disables the function; others enable it.
// RULE2: method codes pick 3/4-digit BCD or 12/16-bit binary, +2 adds compensation.
// RULE3: methods 0 to 3 ignore digit_input_lines[15:12].
// RULE4: binary takes the word as hex; BCD takes each nibble as a digit.
// RULE5: read timing 0 captures continuously, unfiltered, strobe ignored.
// RULE6: read timing 1 captures only while read_strobe is high, else holds.
// RULE7: read timing 10 captures continuously through a skew filter.
// RULE8: the driver holds each word for at least 20 ms.
// RULE9: powering up with strobe low under timing 1 reads all lines as zero.
// RULE10: input zero maps to the bias of the active code; where gain is below bias the code outputs the gain.
// RULE11: full-scale input maps to the gain of the active code.
// RULE12: the command never exceeds the active gain; the code does not limit direct mode (gain 9999).
// RULE13: gain 9999 uses the value times the increment as the command.
// RULE14: in direct mode the bias settings are ignored.
// RULE15: bias and gain accept 0 to 400 Hz, gain also 9999; bias resets 0.
// RULE16: gains reset to 60 Hz, or 50 Hz in the regional variant.
// RULE17: increment accepts 0 to 3, resets 1, locked while running, survives clear.
// RULE18: increment 0..3 selects 10, 1, 0.1, 0.01 Hz per count.
// RULE19: a BCD digit above 9 is refused and the old value kept.
// RULE20: between bias and gain the command interpolates linearly; where gain is below bias the code holds the gain.
module pfs_setpoint
    import pfs_pkg::*;
#(
    parameter bit          REGION_50HZ = 1'b0,
    parameter int unsigned FILT_CYC    = `PFS_FILT_US * `PFS_CLK_MHZ
)
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [15:0] digit_input_lines_in,
    input  wire logic        read_strobe_in,
    input  wire logic        drive_running_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    output logic      [31:0] freq_cmd_out,
    output logic             setpoint_active_out,
    output logic             analog_comp_out
);
    localparam logic [15:0] GAIN_RST = REGION_50HZ ? `PFS_GAIN50 : `PFS_GAIN60;
    localparam logic [22:0] FILT_END = 23'(FILT_CYC);

    pfs_dp_if dp ();

    logic [16:0] sy1_r, sy1_nxt, sy2_r, sy2_nxt;
    pfs_word_t   method_r, method_nxt, rtime_r, rtime_nxt;
    pfs_word_t   bcdb_r, bcdb_nxt, bcdg_r, bcdg_nxt;
    pfs_word_t   binb_r, binb_nxt, bing_r, bing_nxt;
    logic [1:0]  inc_r, inc_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    pfs_word_t   last_r, last_nxt, cap_r, cap_nxt, acc_r, acc_nxt;
    logic [22:0] fcnt_r, fcnt_nxt;
    logic        bad_r, bad_nxt, start_r, start_nxt;
    logic [31:0] freq_r, freq_nxt;
    logic        act_r, act_nxt, comp_r, comp_nxt;
    logic        enabled, narrow, is_bcd, wr_ok, bulk_clr;
    pfs_word_t   masked, wv;

    // decoded view of the settings
    always_comb begin
        wv       = reg_wdata_in[15:0];
        enabled  = (method_r != `PFS_OFF); // RULE1
        narrow   = (method_r <= `PFS_M_NARROW); // RULE3
        is_bcd   = ~method_r[0]; // RULE2
        masked   = narrow ? {4'h0, sy2_r[11:0]} : sy2_r[15:0]; // RULE3
        bulk_clr = reg_wr_in & (reg_addr_in == `PFS_A_CTRL) & reg_wdata_in[0];
        wr_ok    = (wv <= `PFS_FMAX); // RULE15
    end

    assign dp.word  = cap_r;
    assign dp.bcd   = is_bcd;
    assign dp.wide  = ~narrow;
    assign dp.start = start_r;
    assign dp.sval  = acc_r;
    assign dp.bias  = is_bcd ? bcdb_r : binb_r; // RULE10
    assign dp.gain  = is_bcd ? bcdg_r : bing_r; // RULE11
    assign dp.inc   = inc_r;

    pfs_decode u_dec (
        .dp (dp)
    );

    pfs_scale u_scl (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .dp         (dp)
    );

    // settings and register read port
    always_comb begin
        method_nxt = method_r;
        rtime_nxt  = rtime_r;
        bcdb_nxt   = bcdb_r;
        bcdg_nxt   = bcdg_r;
        binb_nxt   = binb_r;
        bing_nxt   = bing_r;
        inc_nxt    = inc_r;
        rdata_nxt  = 32'h00000000;
        if (bulk_clr) begin
            method_nxt = `PFS_OFF;
            rtime_nxt  = `PFS_RT_FREE;
            bcdb_nxt   = `PFS_BIAS_RST; // RULE15
            binb_nxt   = `PFS_BIAS_RST;
            bcdg_nxt   = GAIN_RST; // RULE16
            bing_nxt   = GAIN_RST;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `PFS_A_METHOD:
                    if (wv == `PFS_OFF || wv <= `PFS_M_NARROW || (wv >= `PFS_M_WIDE && wv <= `PFS_M_LAST))
                        method_nxt = wv; // RULE1 RULE2
                `PFS_A_RTIME:
                    if (wv == `PFS_RT_FREE || wv == `PFS_RT_STRB || wv == `PFS_RT_FILT) rtime_nxt = wv;
                `PFS_A_BCDBIAS: if (wr_ok) bcdb_nxt = wv; // RULE15
                `PFS_A_BCDGAIN: if (wr_ok || wv == `PFS_DIRECT) bcdg_nxt = wv; // RULE15
                `PFS_A_BINBIAS: if (wr_ok) binb_nxt = wv; // RULE15
                `PFS_A_BINGAIN: if (wr_ok || wv == `PFS_DIRECT) bing_nxt = wv; // RULE15
                `PFS_A_INC: if (!drive_running_in && wv <= `PFS_INC_MAX) inc_nxt = wv[1:0]; // RULE17
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `PFS_A_METHOD:  rdata_nxt = {16'h0000, method_r};
                `PFS_A_RTIME:   rdata_nxt = {16'h0000, rtime_r};
                `PFS_A_BCDBIAS: rdata_nxt = {16'h0000, bcdb_r};
                `PFS_A_BCDGAIN: rdata_nxt = {16'h0000, bcdg_r};
                `PFS_A_BINBIAS: rdata_nxt = {16'h0000, binb_r};
                `PFS_A_BINGAIN: rdata_nxt = {16'h0000, bing_r};
                `PFS_A_INC:     rdata_nxt = {30'h0000000, inc_r};
                `PFS_A_CMD:     rdata_nxt = freq_r;
                `PFS_A_STAT:    rdata_nxt = {12'h000, bad_r, dp.busy, comp_r, act_r, acc_r};
                default:        rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // capture, filter and acceptance of the input word
    always_comb begin
        sy1_nxt  = {read_strobe_in, digit_input_lines_in};
        sy2_nxt  = sy1_r;
        last_nxt = masked;
        fcnt_nxt = fcnt_r;
        cap_nxt  = cap_r;
        acc_nxt  = acc_r;
        bad_nxt  = bad_r;
        // skew filter: a word counts once it has stood unchanged for the window
        if (masked != last_r) fcnt_nxt = 23'h000000; // RULE7 RULE8
        else if (fcnt_r != FILT_END) fcnt_nxt = fcnt_r + 23'h000001;
        unique case (rtime_r)
            `PFS_RT_STRB: if (sy2_r[16]) cap_nxt = masked; // RULE6 RULE9
            `PFS_RT_FILT: if (fcnt_r == FILT_END) cap_nxt = last_r; // RULE7
            default:      cap_nxt = masked; // RULE5
        endcase
        if (dp.bad) begin
            bad_nxt = 1'b1; // RULE19
        end else begin
            acc_nxt = dp.value; // RULE4
            bad_nxt = 1'b0;
        end
        // any write to the method register, legal or not, drops the old value to zero
        if (reg_wr_in && reg_addr_in == `PFS_A_METHOD) begin
            cap_nxt = 16'h0000;
            acc_nxt = 16'h0000;
        end
    end

    // command output, refreshed whenever the scaler finishes
    always_comb begin
        start_nxt = enabled & ~dp.busy & ~start_r & ~dp.done;
        freq_nxt  = freq_r;
        act_nxt   = act_r;
        // compensation codes sit in bit 1 of the narrow codes and bit 2 of the wide ones
        comp_nxt  = enabled & (narrow ? method_r[1] : method_r[2]); // RULE2
        if (!enabled) begin
            freq_nxt = 32'h00000000; // RULE1
            act_nxt  = 1'b0;
        end else if (dp.done) begin
            freq_nxt = dp.result; // RULE12
            act_nxt  = 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sy1_r    <= 17'h00000;
            sy2_r    <= 17'h00000;
            method_r <= `PFS_OFF; // RULE1
            rtime_r  <= `PFS_RT_FREE;
            bcdb_r   <= `PFS_BIAS_RST;
            bcdg_r   <= GAIN_RST;
            binb_r   <= `PFS_BIAS_RST;
            bing_r   <= GAIN_RST;
            inc_r    <= `PFS_INC_RST; // RULE17
            rdata_r  <= 32'h00000000;
            last_r   <= 16'h0000;
            cap_r    <= 16'h0000; // RULE9
            acc_r    <= 16'h0000;
            fcnt_r   <= 23'h000000;
            bad_r    <= 1'b0;
            start_r  <= 1'b0;
            freq_r   <= 32'h00000000;
            act_r    <= 1'b0;
            comp_r   <= 1'b0;
        end else begin
            sy1_r    <= sy1_nxt;
            sy2_r    <= sy2_nxt;
            method_r <= method_nxt;
            rtime_r  <= rtime_nxt;
            bcdb_r   <= bcdb_nxt;
            bcdg_r   <= bcdg_nxt;
            binb_r   <= binb_nxt;
            bing_r   <= bing_nxt;
            inc_r    <= inc_nxt;
            rdata_r  <= rdata_nxt;
            last_r   <= last_nxt;
            cap_r    <= cap_nxt;
            acc_r    <= acc_nxt;
            fcnt_r   <= fcnt_nxt;
            bad_r    <= bad_nxt;
            start_r  <= start_nxt;
            freq_r   <= freq_nxt;
            act_r    <= act_nxt;
            comp_r   <= comp_nxt;
        end
    end

    assign reg_rdata_out       = rdata_r;
    assign freq_cmd_out        = freq_r;
    assign setpoint_active_out = act_r;
    assign analog_comp_out     = comp_r;
endmodule // pfs_setpoint

/* test/pfs_setpoint_assertions.sv */
// Purpose: port-level checks of the setpoint block
// Assumes: bound into pfs_setpoint, one clock domain
// Notes:   method and gains are shadowed from accepted bus writes
`include "pfs_defines.svh"
module pfs_setpoint_chk #(
    parameter bit          REGION_50HZ = 1'b0,
    parameter int unsigned FILT_CYC    = 8
)
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reg_rdata_out,
    input  wire logic [31:0] freq_cmd_out,
    input  wire logic        setpoint_active_out,
    input  wire logic        analog_comp_out
);
    localparam logic [15:0] GRST = REGION_50HZ ? `PFS_GAIN50 : `PFS_GAIN60;
    logic [15:0] meth_r, meth_nxt, bgain_r, bgain_nxt, ngain_r, ngain_nxt, wd, gain_act;
    logic [5:0]  quiet_r, quiet_nxt;
    logic        m_ok, g_ok, off_w, comp_w;
    // legality of written values and the active code
    assign wd       = reg_wdata_in[15:0];
    assign m_ok     = wd <= `PFS_M_NARROW || (wd >= `PFS_M_WIDE && wd <= `PFS_M_LAST) || wd == `PFS_OFF;
    assign g_ok     = wd <= `PFS_FMAX || wd == `PFS_DIRECT;
    assign off_w    = meth_r == `PFS_OFF;
    assign comp_w   = meth_r == 16'h0002 || meth_r == 16'h0003 || meth_r == 16'h000C || meth_r == 16'h000D;
    assign gain_act = meth_r[0] ? ngain_r : bgain_r;
    // shadow settings; bulk clear restores defaults
    always_comb begin
        meth_nxt  = meth_r;
        bgain_nxt = bgain_r;
        ngain_nxt = ngain_r;
        quiet_nxt = (quiet_r == 6'h3F) ? quiet_r : quiet_r + 6'h01;
        if (reg_wr_in) begin
            quiet_nxt = 6'h00;
            if (reg_addr_in == `PFS_A_METHOD && m_ok) meth_nxt = wd;
            if (reg_addr_in == `PFS_A_BCDGAIN && g_ok) bgain_nxt = wd;
            if (reg_addr_in == `PFS_A_BINGAIN && g_ok) ngain_nxt = wd;
            if (reg_addr_in == `PFS_A_CTRL && reg_wdata_in[0]) begin
                meth_nxt  = `PFS_OFF;
                bgain_nxt = GRST;
                ngain_nxt = GRST;
            end
        end
    end
    // shadow registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            meth_r  <= `PFS_OFF;
            bgain_r <= GRST;
            ngain_r <= GRST;
            quiet_r <= 6'h00;
        end else begin
            meth_r  <= meth_nxt;
            bgain_r <= bgain_nxt;
            ngain_r <= ngain_nxt;
            quiet_r <= quiet_nxt;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence off_settled;
        off_w ##1 off_w ##1 off_w;
    endsequence
    sequence cmd_read;
        reg_rd_in && reg_addr_in == `PFS_A_CMD;
    endsequence
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero outside answer cycle");
    read_cmd_a: assert property (cmd_read |=> reg_rdata_out == $past(freq_cmd_out))
        else $error("command read differs from command output");
    unmapped_read_a: assert property (reg_rd_in && reg_addr_in > `PFS_A_STAT |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    method_read_a: assert property (reg_rd_in && reg_addr_in == `PFS_A_METHOD |=> reg_rdata_out == {16'h0, $past(meth_r)})
        else $error("method readback wrong");
    gain_read_a: assert property (reg_rd_in && reg_addr_in == `PFS_A_BCDGAIN |=> reg_rdata_out == {16'h0, $past(bgain_r)})
        else $error("gain readback wrong");
    off_zero_a: assert property (off_settled |-> freq_cmd_out == 32'h0 && !setpoint_active_out)
        else $error("command or active while function off");
    active_on_a: assert property ($rose(setpoint_active_out) |-> !off_w)
        else $error("active rose while function off");
    gain_limit_a: assert property (quiet_r == 6'h3F && !off_w && gain_act != `PFS_DIRECT |-> freq_cmd_out <= {16'h0, gain_act})
        else $error("command above active gain");
    comp_flag_a: assert property (quiet_r >= 6'h04 |-> analog_comp_out == comp_w)
        else $error("compensation flag wrong for method");
endmodule // pfs_setpoint_chk
bind pfs_setpoint pfs_setpoint_chk #(.REGION_50HZ(REGION_50HZ), .FILT_CYC(FILT_CYC)) u_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .freq_cmd_out(freq_cmd_out),
    .setpoint_active_out(setpoint_active_out), .analog_comp_out(analog_comp_out));

/* test/pfs_contact_model.sv */
// Purpose: contacts or controller outputs driving setpoint lines and strobe
// Assumes: open lines read as off
// Notes:   HOLD_CYC stands in for the minimum word hold time
module pfs_contact_model #(
    parameter int unsigned HOLD_CYC = 50
)
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [15:0] word_in,
    input  wire logic        strobe_in,
    input  wire logic        glitch_in,
    output logic      [15:0] lines_out,
    output logic             strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lines_nxt, hold_r, hold_nxt;
    // a new word goes out once the old one has stood its span, or at once while glitch_in is high
    always_comb begin
        lines_nxt = lines_out;
        hold_nxt  = (hold_r < 16'(HOLD_CYC)) ? hold_r + 16'h0001 : hold_r;
        if (word_in != lines_out && (hold_r >= 16'(HOLD_CYC) || glitch_in)) begin
            lines_nxt = word_in;
            hold_nxt  = 16'h0000;
        end
    end
    // line and strobe registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lines_out  <= 16'h0000;
            hold_r     <= 16'h0000;
            strobe_out <= 1'b0;
        end else begin
            lines_out  <= lines_nxt;
            hold_r     <= hold_nxt;
            strobe_out <= strobe_in;
        end
    end
endmodule // pfs_contact_model

/* test/tb.sv */
// Purpose: self-checking bench of the setpoint block
// Assumes: short filter window and hold span for simulation
// Notes:   settings reached over the strobe register port
`include "pfs_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MUL [4] = '{`PFS_MUL_0, `PFS_MUL_1, `PFS_MUL_2, `PFS_MUL_3};
    logic        clk = 1'b0, rst = 1'b1, running = 1'b0, wr_s = 1'b0, rd_s = 1'b0, strobe, comp, active;
    logic        m_strobe = 1'b0, m_glitch = 1'b0;
    logic [15:0] lines, m_word = 16'h0000;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, cmd;
    int          err_count = 0;
    int          tests_run = 0;
    always #2 clk = ~clk;
    pfs_contact_model #(.HOLD_CYC(50)) u_mdl (.clk_in(clk), .sys_rst_in(rst), .word_in(m_word),
        .strobe_in(m_strobe), .glitch_in(m_glitch), .lines_out(lines), .strobe_out(strobe));
    pfs_setpoint #(.REGION_50HZ(1'b0), .FILT_CYC(8)) DUT (.clk_in(clk), .sys_rst_in(rst),
        .digit_input_lines_in(lines), .read_strobe_in(strobe), .drive_running_in(running),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .freq_cmd_out(cmd), .setpoint_active_out(active), .analog_comp_out(comp));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one write cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
        @(posedge clk);
    endtask
    // one read cycle, data taken in the answer cycle
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        chk(rdata, exp);
    endtask
    // present a word, let it settle, check port and register
    task automatic word_chk(input logic [15:0] w, input logic [31:0] exp);
        m_word <= w;
        repeat (120) @(posedge clk);
        chk(cmd, exp);
        rd_chk(`PFS_A_CMD, exp);
    endtask
    task automatic stop_test;
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(`PFS_A_METHOD, 32'h270F);
        rd_chk(`PFS_A_RTIME, 32'h0);
        rd_chk(`PFS_A_BCDBIAS, 32'h0);
        rd_chk(`PFS_A_BINGAIN, 32'h1770);
        rd_chk(`PFS_A_INC, 32'h1);
        rd_chk(4'hF, 32'h0);
        word_chk(16'h0120, 32'h0);
        wr(`PFS_A_METHOD, 32'h4);
        rd_chk(`PFS_A_METHOD, 32'h270F);
        wr(`PFS_A_BCDGAIN, 32'h9C41);
        rd_chk(`PFS_A_BCDGAIN, 32'h1770);
        wr(`PFS_A_INC, 32'h4);
        running <= 1'b1;
        wr(`PFS_A_INC, 32'h2);
        running <= 1'b0;
        rd_chk(`PFS_A_INC, 32'h1);
        for (int i = 0; i < 8; i++) begin
            wr(`PFS_A_METHOD, (i < 4) ? 32'(i) : 32'(i + 6));
            repeat (4) @(posedge clk);
            chk({31'h0, comp}, {31'h0, i[1]});
        end
        // direct value mode, bias set but ignored
        wr(`PFS_A_BCDGAIN, 32'h270F);
        wr(`PFS_A_BINGAIN, 32'h270F);
        wr(`PFS_A_BCDBIAS, 32'h7D0);
        wr(`PFS_A_METHOD, 32'hA);
        for (int i = 0; i < 4; i++) begin
            wr(`PFS_A_INC, 32'(i));
            word_chk(16'h0120, 32'h78 * MUL[i]);
        end
        chk({31'h0, active}, 32'h1);
        wr(`PFS_A_INC, 32'h1);
        word_chk(16'h01A0, 32'h2EE0);
        word_chk(16'h6325, 32'h9A6B4);
        wr(`PFS_A_METHOD, 32'h0);
        word_chk(16'hF325, 32'h7EF4);
        wr(`PFS_A_METHOD, 32'h1);
        word_chk(16'hF123, 32'h71AC);
        wr(`PFS_A_METHOD, 32'hB);
        word_chk(16'hAB65, 32'h42F374);
        // interpolation between bias and gain
        wr(`PFS_A_BINBIAS, 32'h3E8);
        wr(`PFS_A_BINGAIN, 32'h1388);
        word_chk(16'h0000, 32'h3E8);
        word_chk(16'hFFFF, 32'h1388);
        word_chk(16'h8000, 32'hBB8);
        wr(`PFS_A_BINBIAS, 32'h1388);
        wr(`PFS_A_BINGAIN, 32'h3E8);
        word_chk(16'h0000, 32'h3E8);
        // read timing by strobe, then free and filtered
        wr(`PFS_A_BINGAIN, 32'h270F);
        wr(`PFS_A_RTIME, 32'h1);
        m_strobe <= 1'b1;
        word_chk(16'h0050, 32'h1F40);
        m_strobe <= 1'b0;
        word_chk(16'h0070, 32'h1F40);
        m_strobe <= 1'b1;
        word_chk(16'h0070, 32'h2BC0);
        m_strobe <= 1'b0;
        wr(`PFS_A_RTIME, 32'h0);
        word_chk(16'h0030, 32'h12C0);
        wr(`PFS_A_RTIME, 32'hA);
        word_chk(16'h0030, 32'h12C0);
        m_glitch <= 1'b1;
        m_word   <= 16'h0031;
        repeat (3) @(posedge clk);
        m_word   <= 16'h0030;
        @(posedge clk);
        m_glitch <= 1'b0;
        repeat (60) @(posedge clk);
        chk(cmd, 32'h12C0);
        word_chk(16'h0031, 32'h1324);
        // bulk clear keeps the increment
        wr(`PFS_A_INC, 32'h3);
        wr(`PFS_A_CTRL, 32'h1);
        rd_chk(`PFS_A_INC, 32'h3);
        rd_chk(`PFS_A_BINGAIN, 32'h1770);
        rd_chk(`PFS_A_BINBIAS, 32'h0);
        word_chk(16'h0040, 32'h0);
        // second reset: strobe timing with strobe low reads all lines as zero
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr(`PFS_A_RTIME, 32'h1);
        wr(`PFS_A_BINBIAS, 32'h7D0);
        wr(`PFS_A_METHOD, 32'hB);
        word_chk(16'h0040, 32'h7D0);
        // bcd interpolation over 999 and 9999
        m_strobe <= 1'b1;
        wr(`PFS_A_METHOD, 32'h0);
        word_chk(16'h0500, 32'hBBB);
        wr(`PFS_A_METHOD, 32'hA);
        word_chk(16'h5000, 32'hBB8);
        stop_test();
    end
endmodule // tb
